// ===== rtl/phy_interrupt_manager.sv
// interrupt flags, mask, mode select and active-low interrupt output of the transceiver
`include "irq_mgr_cfg.svh"

module phy_interrupt_manager #(
    parameter int unsigned ENERGY_DELAY_CYC = `ENERGY_DELAY_CYC,
    parameter int unsigned ENERGY_PULSE_CYC = `ENERGY_PULSE_CYC
) (
    input  wire logic                      CLK,
    input  wire logic                      RST,
    input  wire irq_mgr_pkg::reg_req_t     REG_REQ,
    input  wire irq_mgr_pkg::phy_status_t  STATUS,
    input  wire logic                      RENEGOTIATE,
    output logic [15:0]                    REG_RDATA,
    output logic                           IRQ_OUT_N
);

    irq_mgr_pkg::energy_st_t en_st_q;
    logic [7:0]  stat_v;
    logic [7:0]  prev_q;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic [7:0]  pri_clr;
    logic [7:0]  wr_one;
    logic [7:0]  flags;
    logic [7:0]  mask_q;
    logic        alt_q;
    logic        rd_status;
    logic        rd_exp;
    logic        rd_flags;
    logic        wr_flags;
    logic        wr_mask;
    logic        wr_mode;
    logic        pulse_on;
    logic [31:0] en_cnt_q;
    logic [15:0] rdata_q;
    logic        irq_n_q;
    logic        link_loss;

    // source vector, bit i is register bit i+1; link-down is the inverted link level
    assign stat_v = {|STATUS.wake, STATUS.energy_detect, STATUS.an_complete, STATUS.remote_fault,
                     ~STATUS.link_status, STATUS.lp_ack, STATUS.par_det_fault, STATUS.page_received};

    // register port decode, one strobe per cycle from the frame decoder
    assign rd_status = REG_REQ.rd & (REG_REQ.addr == `REG_BASIC_STATUS);
    assign rd_exp    = REG_REQ.rd & (REG_REQ.addr == `REG_EXPANSION);
    assign rd_flags  = REG_REQ.rd & (REG_REQ.addr == `REG_IRQ_FLAGS);
    assign wr_flags  = REG_REQ.wr & (REG_REQ.addr == `REG_IRQ_FLAGS);
    assign wr_mask   = REG_REQ.wr & (REG_REQ.addr == `REG_IRQ_MASK);
    assign wr_mode   = REG_REQ.wr & (REG_REQ.addr == `REG_MODE_CTRL);

    // previous levels for edge detection
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prev_q <= `PREV_RST;
        end else begin
            prev_q <= stat_v;
        end
    end

    assign rise      = stat_v & ~prev_q;
    assign fall      = prev_q & ~stat_v;
    assign link_loss = rise[3];

    // primary deassert events per source; reads of the flag register clear every source
    assign pri_clr = {8{rd_flags}} | {~stat_v[7],
                                      fall[6],
                                      fall[5],
                                      fall[4] | rd_status,
                                      rd_status,
                                      fall[2],
                                      fall[1] | rd_exp | RENEGOTIATE | link_loss,
                                      fall[0] | rd_exp | RENEGOTIATE | link_loss};

    assign wr_one = {8{wr_flags & alt_q}} & REG_REQ.wdata[`SRC_MSB:`SRC_LSB];

    // one flag cell per source; energy flag comes out of reset set
    for (genvar i = 0; i < 8; i++) begin : g_src
        irq_flag_cell #(
            .RST_VAL (1'(`FLAG_RST >> i))
        ) u_cell (
            .CLK     (CLK),
            .RST     (RST),
            .set_ev  (rise[i]),
            .pri_clr (pri_clr[i]),
            .alt_ok  (~stat_v[i]),
            .wr_one  (wr_one[i]),
            .alt     (alt_q),
            .flag_q  (flags[i])
        );
    end

    // mode select, only this bit of the mode register lives here
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            alt_q <= 1'b0;
        end else if (wr_mode) begin
            alt_q <= REG_REQ.wdata[`ALT_SEL_BIT];
        end
    end

    // mask register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mask_q <= `MASK_RST;
        end else if (wr_mask) begin
            mask_q <= REG_REQ.wdata[`SRC_MSB:`SRC_LSB];
        end
    end

    // delayed energy pulse; leaves at once when the mask is dropped or alternate mode starts
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            en_st_q  <= irq_mgr_pkg::EN_IDLE;
            en_cnt_q <= 32'h0;
        end else if (alt_q || !mask_q[6]) begin
            en_st_q  <= irq_mgr_pkg::EN_IDLE;
            en_cnt_q <= 32'h0;
        end else begin
            case (en_st_q)
                irq_mgr_pkg::EN_IDLE: begin
                    if (flags[6] && pri_clr[6] && !rise[6] && stat_v[6]) begin
                        en_st_q <= irq_mgr_pkg::EN_ARMED;
                    end
                end
                irq_mgr_pkg::EN_ARMED: begin
                    if (fall[6]) begin
                        en_st_q  <= irq_mgr_pkg::EN_WAIT;
                        en_cnt_q <= 32'h0;
                    end
                end
                irq_mgr_pkg::EN_WAIT: begin
                    if (en_cnt_q == ENERGY_DELAY_CYC - 1) begin
                        en_st_q  <= irq_mgr_pkg::EN_PULSE;
                        en_cnt_q <= 32'h0;
                    end else begin
                        en_cnt_q <= en_cnt_q + 32'h1;
                    end
                end
                irq_mgr_pkg::EN_PULSE: begin
                    if (en_cnt_q == ENERGY_PULSE_CYC - 1) begin
                        en_st_q  <= irq_mgr_pkg::EN_IDLE;
                        en_cnt_q <= 32'h0;
                    end else begin
                        en_cnt_q <= en_cnt_q + 32'h1;
                    end
                end
                default: begin
                    en_st_q  <= irq_mgr_pkg::EN_IDLE;
                    en_cnt_q <= 32'h0;
                end
            endcase
        end
    end

    assign pulse_on = (en_st_q == irq_mgr_pkg::EN_PULSE) & mask_q[6];

    // output flop keeps the pin glitch free; only masked-in flags and the masked-in energy pulse reach it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= ~(|(flags & mask_q) | pulse_on);
        end
    end

    // read data registered, value before any read clear of the same cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= 16'h0000;
        end else if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                `REG_IRQ_FLAGS: rdata_q <= {7'h00, flags, 1'b0};
                `REG_IRQ_MASK:  rdata_q <= {7'h00, mask_q, 1'b0};
                `REG_MODE_CTRL: rdata_q <= 16'(alt_q) << `ALT_SEL_BIT;
                default:        rdata_q <= 16'h0000;
            endcase
        end
    end

    assign REG_RDATA = rdata_q;
    assign IRQ_OUT_N = irq_n_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_reset_mode: assert property (@(posedge CLK) $fell(RST) |-> !alt_q)
        else $error("alternate mode active after reset");
    a_irq_assert: assert property ((|(flags & mask_q)) |=> !IRQ_OUT_N)
        else $error("masked flag did not drive output");
    a_irq_release: assert property ((!(|(flags & mask_q)) && !pulse_on) |=> IRQ_OUT_N)
        else $error("output active without masked flag");
    a_wake_clear: assert property ((!alt_q && !stat_v[7]) |=> !flags[7])
        else $error("wake flag stayed with wake bits low");
    a_link_rdclr: assert property ((!alt_q && rd_status && !rise[3]) |=> !flags[3])
        else $error("link down flag survived status read");
    a_page_reneg: assert property ((!alt_q && RENEGOTIATE && !rise[0] && !rise[1]) |=> !flags[0] && !flags[1])
        else $error("page flags survived renegotiation");
    a_energy_pulse: assert property ((en_st_q == irq_mgr_pkg::EN_PULSE && mask_q[6]) |=> !IRQ_OUT_N)
        else $error("energy pulse not on output");
    a_energy_boot: assert property (@(posedge CLK) $fell(RST) |-> flags[6])
        else $error("energy flag not set after reset");
    a_alt_select: assert property ((wr_mode && REG_REQ.wdata[`ALT_SEL_BIT]) |=> alt_q)
        else $error("alternate select not taken");
    a_alt_maskclr: assert property ((alt_q && wr_mask && REG_REQ.wdata == 16'h0000) |=> ##1 IRQ_OUT_N)
        else $error("mask clear did not release output");
    a_alt_clear: assert property ((alt_q && wr_one[6] && !stat_v[6]) |=> !flags[6])
        else $error("write one did not clear idle flag");
    a_flag_layout: assert property (($past(rd_flags) || $past(REG_REQ.rd && REG_REQ.addr == `REG_IRQ_MASK))
        |-> (REG_RDATA[15:9] == 7'h00 && !REG_RDATA[0]))
        else $error("reserved bits read nonzero");

    c_primary_irq: cover property (!alt_q && $fell(IRQ_OUT_N));
    c_alt_release: cover property (alt_q && |wr_one ##2 $rose(IRQ_OUT_N));
    c_energy_pulse: cover property (en_st_q == irq_mgr_pkg::EN_PULSE);

endmodule // phy_interrupt_manager

// ===== rtl/irq_mgr_cfg.svh
// register offsets, field positions, reset values and timing counts of the interrupt manager
`ifndef IRQ_MGR_CFG_SVH
`define IRQ_MGR_CFG_SVH

`define REG_BASIC_STATUS    5'h01
`define REG_EXPANSION       5'h06
`define REG_MODE_CTRL       5'h11
`define REG_IRQ_FLAGS       5'h1D
`define REG_IRQ_MASK        5'h1E

`define ALT_SEL_BIT         6
`define SRC_LSB             1
`define SRC_MSB             8

`define FLAG_RST            8'h40
`define MASK_RST            8'h00
`define PREV_RST            8'h48

`define CLK_KHZ             125000
`define ENERGY_DELAY_MS     1000
`define ENERGY_PULSE_MS     256
`define ENERGY_DELAY_CYC    (`ENERGY_DELAY_MS * `CLK_KHZ)
`define ENERGY_PULSE_CYC    (`ENERGY_PULSE_MS * `CLK_KHZ)

`endif

// ===== rtl/irq_mgr_pkg.sv
// types shared by the interrupt manager files
package irq_mgr_pkg;

    // one register access from the management frame decoder
    typedef struct packed {
        logic [4:0]  addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } reg_req_t;

    // live status levels of the eight interrupt sources
    typedef struct packed {
        logic [3:0] wake;
        logic       energy_detect;
        logic       an_complete;
        logic       remote_fault;
        logic       link_status;
        logic       lp_ack;
        logic       par_det_fault;
        logic       page_received;
    } phy_status_t;

    typedef enum logic [1:0] {
        EN_IDLE,
        EN_ARMED,
        EN_WAIT,
        EN_PULSE
    } energy_st_t;

endpackage

// ===== rtl/irq_flag_cell.sv
// one interrupt source flag with primary and alternate clearing
module irq_flag_cell #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic set_ev,
    input  wire logic pri_clr,
    input  wire logic alt_ok,
    input  wire logic wr_one,
    input  wire logic alt,
    output logic      flag_q
);

    logic clr;

    // alternate mode clears only on a write of one while the source is idle
    assign clr = alt ? (wr_one & alt_ok) : pri_clr;

    // a new event outranks a clear in the same cycle so it is never lost
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flag_q <= RST_VAL;
        end else if (set_ev) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end

    a_set_wins: assert property (@(posedge CLK) disable iff (RST) set_ev |=> flag_q)
        else $error("flag lost an event that met a clear");
    a_alt_hold: assert property (@(posedge CLK) disable iff (RST)
        (alt && flag_q && wr_one && !alt_ok) |=> flag_q)
        else $error("flag cleared while source still active");

endmodule // irq_flag_cell

// ===== testbench/mgmt_host_model.sv
// management frame decoder stand-in that issues one register access at a time
module mgmt_host_model (
    input  wire logic              CLK,
    output irq_mgr_pkg::reg_req_t  REG_REQ
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus at time zero so the block never sees an unknown strobe
    initial begin
        REG_REQ = '0;
    end

    // one strobe cycle; afterwards address and data are inverted so stale values never look valid
    task automatic reg_op(input logic [4:0] a, input logic w, input logic [15:0] d);
        @(posedge CLK);
        #1;
        REG_REQ.addr  = a;
        REG_REQ.wr    = w;
        REG_REQ.rd    = ~w;
        REG_REQ.wdata = d;
        @(posedge CLK);
        #1;
        REG_REQ.addr  = ~a;
        REG_REQ.wr    = 1'b0;
        REG_REQ.rd    = 1'b0;
        REG_REQ.wdata = ~d;
    endtask
endmodule // mgmt_host_model

// ===== testbench/phy_interrupt_manager_tb.sv
// self-checking bench for the interrupt manager: register reads, both modes, energy pulse
module phy_interrupt_manager_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int DLY = 20;
    localparam int PLS = 10;

    logic                    clk;
    logic                    rst;
    irq_mgr_pkg::reg_req_t   req;
    logic [10:0]             sv;
    logic                    reneg;
    logic [15:0]             rdata;
    logic                    irq_n;
    logic                    rd_q;
    logic [15:0]             exp_q[$];
    int                      num_errors;
    int                      cmp_count;
    int                      seed;
    int                      lows;

    phy_interrupt_manager #(.ENERGY_DELAY_CYC(DLY), .ENERGY_PULSE_CYC(PLS)) phy_interrupt_manager_i (
        .CLK(clk), .RST(rst), .REG_REQ(req), .STATUS(irq_mgr_pkg::phy_status_t'(sv)),
        .RENEGOTIATE(reneg), .REG_RDATA(rdata), .IRQ_OUT_N(irq_n));
    mgmt_host_model mgmt_host_model_i (.CLK(clk), .REG_REQ(req));

    always #4 clk = ~clk;

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // reads note their expected word; the watcher compares it when the data lands
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        mgmt_host_model_i.reg_op(a, 1'b0, 16'h0000);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_host_model_i.reg_op(a, 1'b1, d);
    endtask

    // read data is valid one cycle after the strobe
    always @(posedge clk) begin
        rd_q <= req.rd;
        if (rd_q) begin
            if (exp_q.size() == 0) check("unexpected read", rdata, 16'hFFFF);
            else check("read data", rdata, exp_q.pop_front());
        end
    end

    // watchdog sized well above the whole sequence
    initial begin
        #200000;
        num_errors++;
        test_done();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reneg = 1'b0;
        sv = 11'h048;
        rd_q = 1'b0;
        seed = 32'hE54244EF;
        num_errors = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        check("irq idle", {15'h0000, irq_n}, 16'h0001);
        rd(5'h11, 16'h0000);
        rd(5'h1E, 16'h0000);
        rd(5'h05, 16'h0000);
        rd(5'h1D, 16'h0080);
        // detect goes away as on a port with no signal
        sv[6] = 1'b0;
        rd(5'h1D, 16'h0000);
        // masked-out source flags but leaves the output alone
        sv[0] = 1'b1;
        cyc(3);
        check("irq masked out", {15'h0000, irq_n}, 16'h0001);
        rd(5'h1D, 16'h0002);
        sv[0] = 1'b0;
        wr(5'h1E, 16'h01FE);
        // primary mode: every source but energy asserts, then a flag read releases it
        for (int k = 1; k <= 8; k++) begin
            if (k == 7) continue;
            if (k == 8) lows = 7 + ($unsigned($random(seed)) % 4);
            else lows = k - 1;
            sv[lows] = ~sv[lows];
            cyc(3);
            check("irq asserted", {15'h0000, irq_n}, 16'h0000);
            rd(5'h1D, 16'h0001 << k);
            cyc(2);
            check("irq released", {15'h0000, irq_n}, 16'h0001);
            sv[lows] = ~sv[lows];
            cyc(2);
        end
        // link loss and a detect fault together: status read clears only link-down
        sv[3] = 1'b0;
        sv[1] = 1'b1;
        cyc(3);
        check("irq link down", {15'h0000, irq_n}, 16'h0000);
        rd(5'h01, 16'h0000);
        cyc(2);
        check("irq status read", {15'h0000, irq_n}, 16'h0000);
        rd(5'h06, 16'h0000);
        cyc(2);
        check("irq expansion read", {15'h0000, irq_n}, 16'h0001);
        sv[3] = 1'b1;
        sv[1] = 1'b0;
        cyc(2);
        // renegotiation clears a page flag
        sv[0] = 1'b1;
        cyc(3);
        check("irq page", {15'h0000, irq_n}, 16'h0000);
        reneg = 1'b1;
        cyc(1);
        reneg = 1'b0;
        cyc(2);
        check("irq reneg", {15'h0000, irq_n}, 16'h0001);
        sv[0] = 1'b0;
        // alternate mode: write-one clearing depends on the source level
        wr(5'h11, 16'h0040);
        rd(5'h11, 16'h0040);
        sv[4] = 1'b1;
        cyc(3);
        wr(5'h1D, 16'h0020);
        cyc(2);
        rd(5'h1D, 16'h0020);
        check("irq alt held", {15'h0000, irq_n}, 16'h0000);
        sv[4] = 1'b0;
        wr(5'h1D, 16'h0020);
        cyc(2);
        rd(5'h1D, 16'h0000);
        check("irq alt clear", {15'h0000, irq_n}, 16'h0001);
        sv[2] = 1'b1;
        cyc(3);
        check("irq alt ack", {15'h0000, irq_n}, 16'h0000);
        wr(5'h1E, 16'h01F6);
        cyc(2);
        check("irq alt mask", {15'h0000, irq_n}, 16'h0001);
        sv[2] = 1'b0;
        wr(5'h1D, 16'h0008);
        // energy released while high yields one delayed pulse after detect falls
        wr(5'h11, 16'h0000);
        wr(5'h1E, 16'h0080);
        sv[6] = 1'b1;
        cyc(3);
        check("irq energy", {15'h0000, irq_n}, 16'h0000);
        rd(5'h1D, 16'h0080);
        cyc(2);
        sv[6] = 1'b0;
        lows = 0;
        repeat (DLY + PLS + 20) begin
            cyc(1);
            if (irq_n === 1'b0) lows++;
        end
        check("energy pulse", 16'(lows), 16'(PLS));
        // alternate energy release: cable out then write one, or drop the mask
        wr(5'h11, 16'h0040);
        sv[6] = 1'b1;
        cyc(3);
        check("irq alt energy", {15'h0000, irq_n}, 16'h0000);
        sv[6] = 1'b0;
        wr(5'h1D, 16'h0080);
        cyc(2);
        check("irq alt energy clear", {15'h0000, irq_n}, 16'h0001);
        sv[6] = 1'b1;
        cyc(3);
        check("irq alt energy again", {15'h0000, irq_n}, 16'h0000);
        wr(5'h1E, 16'h0000);
        cyc(2);
        check("irq alt energy unmask", {15'h0000, irq_n}, 16'h0001);
        sv[6] = 1'b0;
        wr(5'h1E, 16'h0000);
        cyc(2);
        test_done();
    end
endmodule // phy_interrupt_manager_tb
